// ---- rdet_map.svh ----
// register indices, field positions, reset values and codes of the block
`ifndef RDET_MAP_SVH
`define RDET_MAP_SVH

// register indices; byte address is four times the index
`define IDX_DISCARD_CMD 16'h1c09
`define IDX_DISCARD_WVAL 16'h1c0a
`define IDX_DISCARD_RVAL 16'h1c0b
`define IDX_EGRESS_TAG 16'h1c0c

// table command fields
`define CMD_DIR_BIT 4
`define CMD_IDX_MSB 3
`define CMD_MASK 32'h0000_001f

// probability value fields
`define PROB_MSB 9
`define PROB_MASK 32'h0000_03ff

// egress tag control fields for port 2
`define ETAG_INSERT_BIT 21
`define ETAG_CHG_VID_BIT 20
`define ETAG_CHG_PRI_BIT 19
`define ETAG_CHG_TAG_BIT 18
`define ETAG_TYPE_MSB 17
`define ETAG_TYPE_LSB 16
`define ETAG_MASK 32'h003f_0000

// reset values
`define RST_CMD 32'h0000_0000
`define RST_WVAL 32'h0000_0000
`define RST_RVAL 32'h0000_0000
`define RST_ETAG 32'h0000_0000
`define RST_LFSR 16'hace1

// egress type codes
`define ETYPE_DUMB 2'h0
`define ETYPE_ACCESS 2'h1
`define ETYPE_HYBRID 2'h2
`define ETYPE_CPU 2'h3

`endif

// ---- rdet_pkg.sv ----
// types shared by the discard table and egress tag logic
package rdet_pkg;

   // kind of frame seen by the egress editor
   typedef enum logic [1:0] {
      PKT_UNTAGGED,
      PKT_PRIO_TAGGED,
      PKT_REGULAR_TAGGED,
      PKT_SPECIAL_TAGGED
   } pkt_class_t;

   // what the egress editor does to the frame
   typedef enum logic [2:0] {
      ACT_PASS,
      ACT_STRIP,
      ACT_INSERT,
      ACT_REWRITE,
      ACT_ADD_SPECIAL
   } tag_action_t;

   // per-port tag controls taken from the register
   typedef struct packed {
      logic insert_tag;
      logic chg_vid;
      logic chg_prio;
      logic chg_tag;
      logic [1:0] etype;
   } tag_ctrl_t;

   // frame header and lookup results on the packet path
   typedef struct packed {
      pkt_class_t pclass;
      logic [11:0] in_vid;
      logic [2:0] in_prio;
      logic [11:0] ingress_vid;
      logic [2:0] ingress_prio;
      logic [11:0] egress_vid;
      logic [2:0] egress_prio;
      logic untag_default;
      logic untag_incoming;
   } tag_in_t;

   // editing decision
   typedef struct packed {
      tag_action_t action;
      logic [11:0] vid;
      logic [2:0] prio;
   } tag_out_t;

endpackage : rdet_pkg

// ---- discard_table_mem.sv ----
// sixteen-entry probability memory, one write port and two read ports
`timescale 1ns/10ps
module discard_table_mem (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic wr_en,
   input wire logic [3:0] wr_idx,
   input wire logic [9:0] wr_data,
   input wire logic a_en,
   input wire logic [3:0] a_idx,
   output logic [9:0] a_q,
   input wire logic b_en,
   input wire logic [3:0] b_idx,
   output logic [9:0] b_q
);
   // contents are not reset on purpose: software fills the table
   logic [9:0] mem [0:15];

   // write port
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
   end

   // registered read ports; a holds for the host, b for packets
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         a_q <= 10'h000;
         b_q <= 10'h000;
      end else begin
         if (a_en) begin
            a_q <= mem[a_idx];
         end
         if (b_en) begin
            b_q <= mem[b_idx];
         end
      end
   end
endmodule : discard_table_mem

// ---- egress_tag_edit.sv ----
// egress vlan tag decision for one port, registered result
`timescale 1ns/10ps
`include "rdet_map.svh"
module egress_tag_edit (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic req_valid,
   input rdet_pkg::tag_ctrl_t ctrl,
   input rdet_pkg::tag_in_t hdr,
   output logic res_valid,
   output rdet_pkg::tag_out_t res
);
   import rdet_pkg::*;

   tag_out_t res_nxt;
   logic regular_edit;

   // change-tag gates both change controls for regular tags
   assign regular_edit = ctrl.chg_tag
                         & (ctrl.chg_vid | ctrl.chg_prio);

   // decision by egress type and frame kind
   always_comb begin
      res_nxt.action = ACT_PASS;
      res_nxt.vid = hdr.in_vid;
      res_nxt.prio = hdr.in_prio;
      case (ctrl.etype)
         `ETYPE_DUMB: begin
            if (hdr.pclass == PKT_SPECIAL_TAGGED) begin
               res_nxt.action = ACT_STRIP;
            end
         end
         `ETYPE_ACCESS: begin
            if (hdr.pclass != PKT_UNTAGGED) begin
               res_nxt.action = ACT_STRIP;
            end
         end
         `ETYPE_HYBRID: begin
            case (hdr.pclass)
               PKT_UNTAGGED: begin
                  if (ctrl.insert_tag
                      && !hdr.untag_default) begin
                     res_nxt.action = ACT_INSERT;
                     res_nxt.vid = hdr.ingress_vid;
                     res_nxt.prio = hdr.ingress_prio;
                  end
               end
               PKT_PRIO_TAGGED: begin
                  // vid always replaced, change-tag plays no part
                  res_nxt.action = ACT_REWRITE;
                  res_nxt.vid = hdr.ingress_vid;
               end
               PKT_REGULAR_TAGGED: begin
                  if (regular_edit && hdr.untag_incoming) begin
                     res_nxt.action = ACT_STRIP;
                  end else if (regular_edit) begin
                     res_nxt.action = ACT_REWRITE;
                     if (ctrl.chg_vid) begin
                        res_nxt.vid = hdr.egress_vid;
                     end
                     if (ctrl.chg_prio) begin
                        res_nxt.prio = hdr.egress_prio;
                     end
                  end
               end
               default: begin
                  res_nxt.action = ACT_STRIP;
               end
            endcase
         end
         default: begin
            res_nxt.action = ACT_ADD_SPECIAL;
         end
      endcase
   end

   // result register
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         res_valid <= 1'b0;
         res <= '0;
      end else begin
         res_valid <= req_valid;
         if (req_valid) begin
            res <= res_nxt;
         end
      end
   end
endmodule : egress_tag_edit

// ---- random_discard_and_egress_tag_cfg.sv ----
// register bank for the random discard table and egress tag controls
`timescale 1ns/10ps
`include "rdet_map.svh"

// Operation
// - a table entry of n means a drop chance of n in 1024.
// - only yellow packets are subject to the table's drop chance.
// - sixteen entries, picked by the ingress port's buffer usage range.
// - the write value register holds the ten bits a write command stores.
// - the read value register is read-only and shows the last read entry.
// - insert-tag adds the ingress default tag to untagged frames.
// - change-vid with change-tag puts the egress default vid on tags.
// - priority tagged frames in hybrid always take the ingress vid.
// - change-priority with change-tag puts the egress default priority.
// - change-tag gates the change controls for regular tagged frames.
// - the four tag controls act only when the egress type is hybrid.
// - a command write carries read-not-write and a four-bit index.
// - the two-bit egress type picks dumb, access, hybrid or cpu.
module random_discard_and_egress_tag_cfg (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [15:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic pkt_valid,
   input wire logic pkt_yellow,
   input wire logic [7:0] pkt_buf_used,
   output logic verdict_valid,
   output logic verdict_drop,
   input wire logic tag_req_valid,
   input rdet_pkg::tag_in_t tag_in,
   output logic tag_out_valid,
   output rdet_pkg::tag_out_t tag_out
);
   import rdet_pkg::*;

   // byte address of a register index
   // index bits above 13 fall away; the map fits 16 address bits
   function automatic logic [15:0] reg_addr(input logic [15:0] idx);
      reg_addr = {idx[13:0], 2'b00};
   endfunction : reg_addr

   // byte-lane merge of a write into a stored word
   // lanes that are not enabled keep their stored byte
   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      be_merge = (old & ~m) | (wd & m);
   endfunction : be_merge

   // buffer usage to table index: fine steps low, coarse steps high
   // 0 to 63 in steps of 8, 64 to 127 in 16, 128 to 255 in 32
   function automatic logic [3:0] usage_index(input logic [7:0] u);
      if (u[7]) begin
         usage_index = {2'b11, u[6:5]};
      end else if (u[6]) begin
         usage_index = {2'b10, u[5:4]};
      end else begin
         usage_index = {1'b0, u[5:3]};
      end
   endfunction : usage_index

   // software-visible register state
   logic [31:0] cmd_r;
   logic [31:0] wval_r;
   logic [31:0] rval_r;
   logic [31:0] etag_r;

   // bus handshake and read path state
   logic ack_r;
   logic rd_pend_r;
   logic [31:0] readdata_r;

   // random discard pipeline; two stages to match the table read
   logic [15:0] lfsr_r;
   logic s1_valid_r;
   logic s1_yellow_r;
   logic [9:0] s1_rnd_r;
   logic verdict_valid_r;
   logic verdict_drop_r;

   // request decode and access strobes
   logic req;
   logic take;
   logic first;
   logic sel_cmd;
   logic sel_wval;
   logic sel_rval;
   logic sel_etag;
   logic cmd_issue;
   logic tbl_wr;
   logic tbl_rd;
   logic [31:0] cmd_nxt;

   // table read data and register views
   logic [9:0] host_q;
   logic [9:0] pkt_q;
   logic [31:0] rval_view;
   logic [31:0] rd_mux;
   tag_ctrl_t ctrl;

   // address decode
   // only exact word addresses match; others read zero, writes drop
   assign sel_cmd = (avs_address == reg_addr(`IDX_DISCARD_CMD));
   assign sel_wval = (avs_address == reg_addr(`IDX_DISCARD_WVAL));
   assign sel_rval = (avs_address == reg_addr(`IDX_DISCARD_RVAL));
   assign sel_etag = (avs_address == reg_addr(`IDX_EGRESS_TAG));

   // every access takes one wait cycle, then completes at the next edge
   // back-to-back requests each get their own wait cycle
   assign req = avs_read | avs_write;
   assign first = req & ~ack_r;
   assign take = req & ack_r;
   assign avs_waitrequest = first;

   // wait cycle served; the completing edge clears it again
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= first;
      end
   end

   // a command write with the low lane enabled starts a table access
   assign cmd_nxt = be_merge(cmd_r, avs_writedata, avs_byteenable)
                    & `CMD_MASK;
   assign cmd_issue = take & avs_write & sel_cmd & avs_byteenable[0];
   assign tbl_rd = cmd_issue & cmd_nxt[`CMD_DIR_BIT];
   assign tbl_wr = cmd_issue & ~cmd_nxt[`CMD_DIR_BIT];

   // command register keeps its fields for read-back
   // reserved bits are masked so they read back as zero
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cmd_r <= `RST_CMD;
      end else if (take && avs_write && sel_cmd) begin
         cmd_r <= cmd_nxt;
      end
   end

   // write value register; upper bits stay zero
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wval_r <= `RST_WVAL;
      end else if (take && avs_write && sel_wval) begin
         wval_r <= be_merge(wval_r, avs_writedata, avs_byteenable)
                   & `PROB_MASK;
      end
   end

   // egress tag controls; only the port-2 fields are held
   // the other ports' copies are not built and read as zero
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         etag_r <= `RST_ETAG;
      end else if (take && avs_write && sel_etag) begin
         etag_r <= be_merge(etag_r, avs_writedata, avs_byteenable)
                   & `ETAG_MASK;
      end
   end

   // probability table; entries are garbage until software fills them
   // port b serves packets every cycle, so host reads never stall them
   discard_table_mem u_table (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .wr_en(tbl_wr),
      .wr_idx(cmd_nxt[`CMD_IDX_MSB:0]),
      .wr_data(wval_r[`PROB_MSB:0]),
      .a_en(tbl_rd),
      .a_idx(cmd_nxt[`CMD_IDX_MSB:0]),
      .a_q(host_q),
      .b_en(pkt_valid),
      .b_idx(usage_index(pkt_buf_used)),
      .b_q(pkt_q)
   );

   // a table read command has its entry one cycle later
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rd_pend_r <= 1'b0;
      end else begin
         rd_pend_r <= tbl_rd;
      end
   end

   // read value register; not writable by software
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rval_r <= `RST_RVAL;
      end else if (rd_pend_r) begin
         rval_r <= {22'h00_0000, host_q};
      end
   end

   // bypass so a read right behind the command sees the fetched entry
   // the flop copy lags one cycle; the bypass covers that gap
   assign rval_view = rd_pend_r ? {22'h00_0000, host_q} : rval_r;

   // read mux; unmapped addresses read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (sel_cmd) begin
         rd_mux = cmd_r;
      end else if (sel_wval) begin
         rd_mux = wval_r;
      end else if (sel_rval) begin
         rd_mux = rval_view;
      end else if (sel_etag) begin
         rd_mux = etag_r;
      end
   end

   // read data captured in the wait cycle, stands until the next read
   // taking it in the wait cycle keeps the output a plain flop
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         readdata_r <= 32'h0000_0000;
      end else if (first && avs_read) begin
         readdata_r <= rd_mux;
      end
   end

   // bus read data straight from the flop
   assign avs_readdata = readdata_r;

   // free-running random source, a new value every cycle
   // a cheap 16-bit lfsr; its sequence repeats after 65535 cycles
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         lfsr_r <= `RST_LFSR;
      end else begin
         lfsr_r <= {lfsr_r[14:0],
                    lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      end
   end

   // stage one: table lookup in flight, packet flags follow it
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         s1_valid_r <= 1'b0;
         s1_yellow_r <= 1'b0;
      end else begin
         s1_valid_r <= pkt_valid;
         s1_yellow_r <= pkt_yellow;
      end
   end

   // the draw is taken with the packet, so each packet gets its own
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         s1_rnd_r <= 10'h000;
      end else if (pkt_valid) begin
         s1_rnd_r <= lfsr_r[9:0];
      end
   end

   // stage two: the verdict strobe
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         verdict_valid_r <= 1'b0;
      end else begin
         verdict_valid_r <= s1_valid_r;
      end
   end

   // drop when the draw is below the entry, n in 1024; an entry of
   // zero never drops, all ones still passes one packet in 1024
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         verdict_drop_r <= 1'b0;
      end else begin
         verdict_drop_r <= s1_valid_r & s1_yellow_r
                           & (s1_rnd_r < pkt_q);
      end
   end

   // verdict outputs straight from flops
   assign verdict_valid = verdict_valid_r;
   assign verdict_drop = verdict_drop_r;

   // controls fed to the egress editor, one driver for the whole struct
   assign ctrl = '{insert_tag: etag_r[`ETAG_INSERT_BIT],
                   chg_vid: etag_r[`ETAG_CHG_VID_BIT],
                   chg_prio: etag_r[`ETAG_CHG_PRI_BIT],
                   chg_tag: etag_r[`ETAG_CHG_TAG_BIT],
                   etype: etag_r[`ETAG_TYPE_MSB:`ETAG_TYPE_LSB]};

   egress_tag_edit u_tag (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .req_valid(tag_req_valid),
      .ctrl(ctrl),
      .hdr(tag_in),
      .res_valid(tag_out_valid),
      .res(tag_out)
   );
endmodule : random_discard_and_egress_tag_cfg

// ---- rdet_cfg_asserts.sv ----
// port checker for the discard table and egress tag register bank
`timescale 1ns/10ps
`include "rdet_map.svh"
module rdet_cfg_asserts (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [15:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic pkt_valid,
   input wire logic pkt_yellow,
   input wire logic verdict_valid,
   input wire logic verdict_drop,
   input wire logic tag_req_valid,
   input rdet_pkg::tag_in_t tag_in,
   input wire logic tag_out_valid,
   input rdet_pkg::tag_out_t tag_out
);
   import rdet_pkg::*;
   localparam logic [15:0] ETAG_ADDR = `IDX_EGRESS_TAG << 2;
   logic pend_r;
   logic hyb_r;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   // a request already in its wait state; tells first cycle from last
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         pend_r <= 1'b0;
      else
         pend_r <= (avs_read | avs_write) & avs_waitrequest;
   end

   // shadow of the egress type, so hybrid-only behaviour can be judged
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         hyb_r <= 1'b0;
      else if (avs_write && !avs_waitrequest && avs_address == ETAG_ADDR
               && avs_byteenable[2])
         hyb_r <= avs_writedata[17:16] == `ETYPE_HYBRID;
   end

   chk_wait_first: assert property ((avs_read || avs_write) && !pend_r
      |-> avs_waitrequest) else $error("no wait state on new request");
   chk_wait_one: assert property (pend_r |-> !avs_waitrequest)
      else $error("more than one wait state");
   chk_wait_idle: assert property (!(avs_read || avs_write)
      |-> !avs_waitrequest) else $error("waitrequest without request");
   chk_rsvd_zero: assert property (avs_read && !avs_waitrequest
      |-> avs_readdata[31:22] == 10'h000) else $error("reserved bits set");
   chk_verdict_lat: assert property (pkt_valid
      |-> ##2 verdict_valid) else $error("verdict late or missing");
   chk_verdict_cause: assert property (verdict_valid |-> $past(pkt_valid, 2))
      else $error("verdict without packet");
   chk_drop_yellow: assert property (verdict_drop
      |-> verdict_valid && $past(pkt_yellow, 2))
      else $error("drop of a packet that was not yellow");
   chk_tag_lat: assert property (tag_req_valid |=> tag_out_valid)
      else $error("tag result late or missing");
   chk_tag_hold: assert property (!tag_req_valid
      |=> !tag_out_valid && $stable(tag_out)) else $error("tag result moved");
   chk_prio_vid: assert property (tag_req_valid && hyb_r
      && tag_in.pclass == PKT_PRIO_TAGGED |=> tag_out.action == ACT_REWRITE
      && tag_out.vid == $past(tag_in.ingress_vid))
      else $error("priority tag not given ingress vid");
   chk_hybrid_only: assert property (tag_req_valid && !hyb_r
      |=> tag_out.action inside {ACT_PASS, ACT_STRIP, ACT_ADD_SPECIAL})
      else $error("tag edit outside hybrid");
endmodule : rdet_cfg_asserts

bind random_discard_and_egress_tag_cfg rdet_cfg_asserts rdet_cfg_asserts_i (
   .sys_clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_byteenable, .avs_readdata, .avs_waitrequest, .pkt_valid,
   .pkt_yellow, .verdict_valid, .verdict_drop, .tag_req_valid, .tag_in,
   .tag_out_valid, .tag_out);

// ---- random_discard_and_egress_tag_cfg_bench.sv ----
// self-checking bench for the discard table and egress tag register bank
`timescale 1ns/10ps
`include "rdet_map.svh"
module random_discard_and_egress_tag_cfg_bench;
   import rdet_pkg::*;
   logic sys_clk = 1'b0;
   logic nrst, avs_read, avs_write, avs_waitrequest, pkt_valid, pkt_yellow;
   logic verdict_valid, verdict_drop, tag_req_valid, tag_out_valid;
   logic [15:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rdat;
   logic [3:0] avs_byteenable;
   logic [7:0] pkt_buf_used;
   tag_in_t tag_in;
   tag_out_t tag_out;
   int err_count = 0;
   int num_checks = 0;

   random_discard_and_egress_tag_cfg random_discard_and_egress_tag_cfg_i (
      .sys_clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .pkt_valid,
      .pkt_yellow, .pkt_buf_used, .verdict_valid, .verdict_drop,
      .tag_req_valid, .tag_in, .tag_out_valid, .tag_out);

   // 100 MHz clock
   always #5 sys_clk = ~sys_clk;

   task test_done;
      if (err_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // one avalon transfer; request held until waitrequest is seen low
   task bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
            output logic [31:0] rd);
      int n;
      @(posedge sys_clk);
      avs_write <= wr;
      avs_read <= !wr;
      avs_address <= idx << 2;
      avs_writedata <= wd;
      for (n = 0; n < 20; n++) begin
         @(posedge sys_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n == 20) begin
         err_count++;
         test_done();
      end
   endtask : bus

   // value first, then the command that stores it
   task tbl_wr(input logic [3:0] k, input logic [9:0] v);
      bus(1'b1, `IDX_DISCARD_WVAL, {22'h0, v}, rdat);
      bus(1'b1, `IDX_DISCARD_CMD, {28'h0, k}, rdat);
   endtask : tbl_wr

   task t_regs;
      bus(1'b0, `IDX_DISCARD_WVAL, 0, rdat);
      chk(rdat, 0);
      bus(1'b0, `IDX_DISCARD_RVAL, 0, rdat);
      chk(rdat, 0);
      bus(1'b0, `IDX_EGRESS_TAG, 0, rdat);
      chk(rdat, 0);
      bus(1'b0, `IDX_DISCARD_CMD, 0, rdat);
      chk(rdat, 0);
      bus(1'b1, 16'h1c0d, 32'hffff_ffff, rdat);
      bus(1'b0, 16'h1c0d, 0, rdat);
      chk(rdat, 0);
      bus(1'b1, `IDX_DISCARD_WVAL, 32'hffff_ffff, rdat);
      bus(1'b0, `IDX_DISCARD_WVAL, 0, rdat);
      chk(rdat, 32'h0000_03ff);
      // only lane 1 written: the low byte must survive
      avs_byteenable <= 4'h2;
      bus(1'b1, `IDX_DISCARD_WVAL, 32'h0000_0000, rdat);
      avs_byteenable <= 4'hf;
      bus(1'b0, `IDX_DISCARD_WVAL, 0, rdat);
      chk(rdat, 32'h0000_00ff);
      bus(1'b1, `IDX_DISCARD_RVAL, 32'hffff_ffff, rdat);
      bus(1'b0, `IDX_DISCARD_RVAL, 0, rdat);
      chk(rdat, 0);
      bus(1'b1, `IDX_EGRESS_TAG, 32'hffff_ffff, rdat);
      bus(1'b0, `IDX_EGRESS_TAG, 0, rdat);
      chk(rdat, 32'h003f_0000);
   endtask : t_regs

   // every entry gets its own value, the first one all ones
   task t_table;
      int i;
      for (i = 0; i < 16; i++)
         tbl_wr(4'(i), 10'h3ff - 10'(i * 65));
      for (i = 0; i < 16; i++) begin
         bus(1'b1, `IDX_DISCARD_CMD, 32'h0000_0010 | i, rdat);
         bus(1'b0, `IDX_DISCARD_RVAL, 0, rdat);
         chk(rdat, {22'h0, 10'h3ff - 10'(i * 65)});
      end
   endtask : t_table

   task pkt(input logic y, input logic [7:0] b, output logic d);
      @(posedge sys_clk);
      pkt_valid <= 1'b1;
      pkt_yellow <= y;
      pkt_buf_used <= b;
      @(posedge sys_clk);
      pkt_valid <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk(verdict_valid, 1);
      d = verdict_drop;
   endtask : pkt

   // one hot entry; the usage level just below it must never drop
   task t_discard;
      int i, j, hit;
      logic d;
      logic [3:0] ks [4];
      logic [7:0] bs [4];
      ks = '{4'h1, 4'h8, 4'hc, 4'hf};
      bs = '{8'd8, 8'd64, 8'd128, 8'd224};
      for (i = 0; i < 16; i++)
         tbl_wr(4'(i), 10'h000);
      for (i = 0; i < 4; i++) begin
         tbl_wr(ks[i], 10'h3ff);
         hit = 0;
         for (j = 0; j < 8; j++) begin
            pkt(1'b1, bs[i], d);
            hit += d;
            // judged one by one, so an unknown verdict cannot slip by
            pkt(1'b1, bs[i] - 8'd1, d);
            chk(d, 0);
            pkt(1'b0, bs[i], d);
            chk(d, 0);
         end
         chk(hit >= 4, 1);
         tbl_wr(ks[i], 10'h000);
      end
   endtask : t_discard

   // c is insert, change vid, change priority, change tag, egress type
   task tag(input logic [5:0] c, input pkt_class_t cl, input logic ud,
            input logic ui, input tag_action_t ea, input logic [14:0] evp);
      bus(1'b1, `IDX_EGRESS_TAG, {10'h0, c, 16'h0}, rdat);
      @(posedge sys_clk);
      tag_req_valid <= 1'b1;
      tag_in <= '{cl, 12'h123, 3'h1, 12'h456, 3'h2, 12'h789, 3'h3, ud, ui};
      @(posedge sys_clk);
      tag_req_valid <= 1'b0;
      #1;
      chk(tag_out_valid, 1);
      chk(tag_out.action, ea);
      if (evp != 15'h0)
         chk({tag_out.vid, tag_out.prio}, evp);
   endtask : tag

   task t_tags;
      tag(6'h22, PKT_UNTAGGED, 0, 0, ACT_INSERT, {12'h456, 3'h2});
      tag(6'h22, PKT_UNTAGGED, 1, 0, ACT_PASS, 0);
      tag(6'h16, PKT_REGULAR_TAGGED, 0, 0, ACT_REWRITE,
          {12'h789, 3'h1});
      tag(6'h16, PKT_REGULAR_TAGGED, 0, 1, ACT_STRIP, 0);
      tag(6'h0e, PKT_REGULAR_TAGGED, 0, 0, ACT_REWRITE,
          {12'h123, 3'h3});
      tag(6'h0e, PKT_REGULAR_TAGGED, 0, 1, ACT_STRIP, 0);
      tag(6'h1a, PKT_REGULAR_TAGGED, 0, 0, ACT_PASS, 0);
      tag(6'h02, PKT_PRIO_TAGGED, 1, 1, ACT_REWRITE,
          {12'h456, 3'h1});
      tag(6'h3c, PKT_UNTAGGED, 0, 0, ACT_PASS, 0);
      tag(6'h3d, PKT_REGULAR_TAGGED, 0, 0, ACT_STRIP, 0);
      tag(6'h3f, PKT_REGULAR_TAGGED, 0, 0, ACT_ADD_SPECIAL, 0);
      tag(6'h00, PKT_SPECIAL_TAGGED, 0, 0, ACT_STRIP, 0);
   endtask : t_tags

   // reset for five cycles, then the scenarios in turn
   initial begin
      nrst = 1'b0;
      {avs_read, avs_write, pkt_valid, pkt_yellow, tag_req_valid} = 5'h0;
      avs_address = 16'h0000;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hf;
      pkt_buf_used = 8'h00;
      tag_in = '0;
      repeat (5) @(posedge sys_clk);
      nrst <= 1'b1;
      t_regs();
      t_table();
      t_tags();
      t_discard();
      test_done();
   end
endmodule : random_discard_and_egress_tag_cfg_bench
